//--- common/exec_state_params.svh
// Purpose: Offsets, field positions, reset values and bus responses for the execution state unit
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Definitions only
`ifndef EXEC_STATE_PARAMS_SVH
`define EXEC_STATE_PARAMS_SVH
// Register byte offsets
`define ESV_OFS_VIEW 8'h00
`define ESV_OFS_SWVIEW 8'h04
`define ESV_OFS_IRQ_STAT 8'h08
`define ESV_OFS_IRQ_MASK 8'h0c
// Field positions inside the execution status view
`define ESV_HI_MSB 26
`define ESV_HI_LSB 25
`define ESV_TBIT_POS 24
`define ESV_LO_MSB 15
`define ESV_LO_LSB 10
`define ESV_REG_LSB 12
// Reset values
`define ESV_TBIT_RST 1'b1
`define ESV_IRQ_RST 3'h0
// Interrupt status bit positions
`define ESV_EV_FAULT 0
`define ESV_EV_SUSP 1
`define ESV_EV_RESUME 2
`define ESV_EV_W 3
// Bus responses
`define ESV_RESP_OK 2'h0
`define ESV_RESP_ERR 2'h2
`endif

//--- common/exec_state_pkg.sv
// Purpose: Types shared by the execution state unit and its users
// Assumes: Nothing beyond the params header
// Notes: Types only; constants live in exec_state_params.svh
package exec_state_pkg;
    // What the split field currently holds
    typedef enum logic [1:0] {MODE_NONE, MODE_BLOCK, MODE_XFER} mode_type;
    // Events reported by the core pipeline, one cycle each
    typedef struct packed {
        logic block_start;   // Conditional-block instruction decoded
        logic [7:0] block_bits; // Condition base and mask
        logic block_step;    // One instruction of the block retired
        logic xfer_suspend;  // Multi-register transfer interrupted
        logic [3:0] xfer_next; // Next register operand number
        logic xfer_resume;   // Interrupt service finished
        logic xfer_done;     // Transfer completed normally
        logic tbit_load;     // Branch-exchange, pop, return or vector fetch
        logic tbit_value;    // Bit 0 of the loaded address or stacked word
        logic exec_try;      // An instruction is about to execute
    } core_event_type;
    // Resume order back to the core
    typedef struct packed {
        logic valid;
        logic [3:0] first_reg;
    } resume_type;
endpackage

//--- rtl/exec_state_unit.sv
// Purpose: Execution-state part of the program status word with an AXI4-Lite view
// Assumes: Core events synchronous to mclk, one-cycle pulses
// Notes: Rules carried by this unit are listed below
// Functional notes
// - Split field in bits 26:25 and 15:10
// - Transfer state keeps bits 26:25 zero
// - Transfer state keeps bits 11:10 zero
// - Suspend records next register in 15:12
// - Resume restarts from register in 15:12
// - Up to four conditional instructions per block
// - State bit 24, read-only, resets to one
// - Branch, pop, return or vector load bit
// - Executing with bit clear raises fault
// - Reserved 23:16 and 9:7 read zero
// - Field valid only in full view
// - Software view reads zero, writes ignored
// - Reset vector bit 0 loads state bit
`timescale 1ns/1ps
`include "exec_state_params.svh"
module exec_state_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire exec_state_pkg::core_event_type core_ev,
    output exec_state_pkg::resume_type resume,
    output logic exec_fault,
    output logic irq,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    // Execution state
    exec_state_pkg::mode_type mode, next_mode; // Meaning of the split field
    logic [7:0] cond, next_cond; // Block bits, or register number in 7:4
    logic tbit, next_tbit; // Instruction-set state
    exec_state_pkg::resume_type next_resume;
    logic next_fault;
    // Interrupt registers
    logic [2:0] irq_stat, next_irq_stat;
    logic [2:0] irq_mask, next_irq_mask;
    logic next_irq;
    // Bus state
    logic aw_held, next_aw_held; // Write address taken, waiting for data
    logic w_held, next_w_held; // Write data taken, waiting for address
    logic [7:0] waddr, next_waddr;
    logic [31:0] wbuf, next_wbuf;
    logic [3:0] wstb, next_wstb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] view; // Full execution status view
    logic do_write; // Both halves of a write are in hand
    logic [2:0] w1c; // Bits cleared by this write

    // Place the split field and the state bit; everything else reads zero
    function automatic logic [31:0] pack_view(input logic [7:0] c, input logic t);
        logic [31:0] v;
        v = 32'h0000_0000; // Reserved 23:16 and 9:7 stay zero
        v[`ESV_HI_MSB:`ESV_HI_LSB] = c[1:0];
        v[`ESV_LO_MSB:`ESV_LO_LSB] = c[7:2];
        v[`ESV_TBIT_POS] = t;
        return v;
    endfunction

    // Encoding of the held state: transfer keeps low pairs zero
    always_comb begin
        view = pack_view(cond, tbit);
    end

    // Next execution state
    always_comb begin
        next_mode = mode;
        next_cond = cond;
        next_tbit = tbit;
        next_resume = '0;
        next_fault = 1'b0;
        if (core_ev.tbit_load) begin
            next_tbit = core_ev.tbit_value;
        end
        if (core_ev.exec_try && !tbit) begin
            // No instruction may run in the wrong state; the core takes the fault
            next_fault = 1'b1;
        end
        if (core_ev.xfer_suspend) begin
            // Register number in 15:12, bits 11:10 and 26:25 forced zero
            next_mode = exec_state_pkg::MODE_XFER;
            next_cond = {core_ev.xfer_next, 4'h0};
        end else if (core_ev.xfer_resume && mode == exec_state_pkg::MODE_XFER) begin
            next_resume.valid = 1'b1;
            next_resume.first_reg = cond[7:4];
        end else if (core_ev.xfer_done && mode == exec_state_pkg::MODE_XFER) begin
            next_mode = exec_state_pkg::MODE_NONE;
            next_cond = 8'h00;
        end else if (core_ev.block_start) begin
            next_mode = exec_state_pkg::MODE_BLOCK;
            next_cond = core_ev.block_bits;
        end else if (core_ev.block_step && mode == exec_state_pkg::MODE_BLOCK) begin
            // Mask shifts left once per instruction; at most four steps
            if (cond[2:0] == 3'h0) begin
                next_mode = exec_state_pkg::MODE_NONE;
                next_cond = 8'h00;
            end else begin
                next_cond = {cond[7:5], cond[3:0], 1'b0};
            end
        end
    end

    // Register execution state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode <= exec_state_pkg::MODE_NONE;
            cond <= 8'h00;
            tbit <= `ESV_TBIT_RST;
            resume <= '0;
            exec_fault <= 1'b0;
        end else begin
            mode <= next_mode;
            cond <= next_cond;
            tbit <= next_tbit;
            resume <= next_resume;
            exec_fault <= next_fault;
        end
    end

    // Bus and interrupt next values
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_waddr = waddr;
        next_wbuf = wbuf;
        next_wstb = wstb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_irq_mask = irq_mask;
        w1c = 3'h0;
        do_write = 1'b0;
        // Address and data may come in either order
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_waddr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_wbuf = wdata;
            next_wstb = wstrb;
        end
        if (aw_held && w_held && !bvalid) begin
            do_write = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `ESV_RESP_OK;
            if (waddr == `ESV_OFS_IRQ_STAT) begin
                if (wstb[0]) begin
                    w1c = wbuf[2:0];
                end
            end else if (waddr == `ESV_OFS_IRQ_MASK) begin
                if (wstb[0]) begin
                    next_irq_mask = wbuf[2:0];
                end
            end else if (waddr == `ESV_OFS_VIEW || waddr == `ESV_OFS_SWVIEW) begin
                // Read-only views: the write is accepted and dropped
                next_bresp = `ESV_RESP_OK;
            end else begin
                next_bresp = `ESV_RESP_ERR;
            end
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        // Reads answer one cycle after the address is taken
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = `ESV_RESP_OK;
            if (araddr == `ESV_OFS_VIEW) begin
                next_rdata = view;
            end else if (araddr == `ESV_OFS_SWVIEW) begin
                next_rdata = 32'h0000_0000;
            end else if (araddr == `ESV_OFS_IRQ_STAT) begin
                next_rdata = {29'h0000_0000, irq_stat};
            end else if (araddr == `ESV_OFS_IRQ_MASK) begin
                next_rdata = {29'h0000_0000, irq_mask};
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = `ESV_RESP_ERR;
            end
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        // One write and one read outstanding at most
        next_awready = !next_aw_held && !next_bvalid && !(awvalid && awready);
        next_wready = !next_w_held && !next_bvalid && !(wvalid && wready);
        next_arready = !next_rvalid && !(arvalid && arready);
        // Sticky events; a set in the clearing cycle wins
        next_irq_stat = (irq_stat & ~w1c) | {next_resume.valid,
            core_ev.xfer_suspend, next_fault};
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // Register bus and interrupt state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= 8'h00;
            wbuf <= 32'h0000_0000;
            wstb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `ESV_RESP_OK;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= `ESV_RESP_OK;
            rdata <= 32'h0000_0000;
            irq_stat <= `ESV_IRQ_RST;
            irq_mask <= `ESV_IRQ_RST;
            irq <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            waddr <= next_waddr;
            wbuf <= next_wbuf;
            wstb <= next_wstb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

    // Checks on the execution state
    sequence s_suspend;
        core_ev.xfer_suspend;
    endsequence
    sequence s_resume_req;
        mode == exec_state_pkg::MODE_XFER && core_ev.xfer_resume && !core_ev.xfer_suspend;
    endsequence

    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        arvalid && arready && araddr == `ESV_OFS_VIEW
        |=> rdata[23:16] == 8'h00 && rdata[9:7] == 3'h0)
        else $error("Reserved view bits not zero");
    a_xfer_hi_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        mode == exec_state_pkg::MODE_XFER |-> view[26:25] == 2'h0)
        else $error("Transfer state with nonzero 26:25");
    a_xfer_lo_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        mode == exec_state_pkg::MODE_XFER |-> view[11:10] == 2'h0)
        else $error("Transfer state with nonzero 11:10");
    a_suspend_rec: assert property (@(posedge mclk) disable iff (!rst_n)
        s_suspend |=> view[15:12] == $past(core_ev.xfer_next))
        else $error("Next register not recorded");
    a_resume_reg: assert property (@(posedge mclk) disable iff (!rst_n)
        s_resume_req |=> resume.valid && resume.first_reg == $past(view[15:12]))
        else $error("Resume register wrong");
    a_block_len: assert property (@(posedge mclk) disable iff (!rst_n)
        core_ev.block_start && !core_ev.xfer_suspend ##1
        (core_ev.block_step && !core_ev.block_start && !core_ev.xfer_suspend)[*4]
        |=> mode == exec_state_pkg::MODE_NONE)
        else $error("Block longer than four");
    a_tbit_reset: assert property (@(posedge mclk)
        !rst_n |=> tbit)
        else $error("State bit not set after reset");
    a_tbit_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        core_ev.exec_try && !tbit |=> exec_fault && irq_stat[`ESV_EV_FAULT])
        else $error("No fault with state bit clear");
    a_sw_view_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        arvalid && arready && araddr == `ESV_OFS_SWVIEW |=> rvalid && rdata == 32'h0)
        else $error("Software view not zero");
    a_done_clears: assert property (@(posedge mclk) disable iff (!rst_n)
        mode == exec_state_pkg::MODE_XFER && core_ev.xfer_done && !core_ev.xfer_suspend
        && !core_ev.xfer_resume |=> cond == 8'h00 && mode == exec_state_pkg::MODE_NONE)
        else $error("Completion did not clear state");
    // The state bit moves only on an explicit load; software cannot reach it
    a_tbit_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !core_ev.tbit_load |=> tbit == $past(tbit))
        else $error("State bit changed without a load");
    // A fault pulse must trace back to an attempt made in the wrong state
    a_fault_cause: assert property (@(posedge mclk) disable iff (!rst_n)
        exec_fault |-> !$past(tbit) && $past(core_ev.exec_try))
        else $error("Fault without a cause");
endmodule // exec_state_unit

//--- tb/execution_state_status_bits_tb_top.sv
// Purpose: Self-checking bench for the execution state unit
// Assumes: Registered AXI4-Lite answers, core events taken at every edge
// Notes: Operands drawn from a fixed seed, corner cases written by hand
`timescale 1ns/1ps
`include "exec_state_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module execution_state_status_bits_tb_top;
    logic mclk = 1'b0; // Core clock, 5 ns period
    logic rst_n = 1'b0; // Synchronous reset, active low
    exec_state_pkg::core_event_type core_ev = '0; // Pipeline event pulses
    exec_state_pkg::resume_type resume;
    logic exec_fault, irq, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    int bad_count = 0; // Mismatches seen
    int tests_run = 0; // Comparisons made
    int seed = 79884; // Fixed seed keeps every run the same
    logic tb_tbit = 1'b1; // Expected state bit
    logic [7:0] tb_cond = 8'h00; // Expected block bits
    logic [3:0] tb_reg = 4'h0; // Expected next register
    logic tb_xfer = 1'b0; // Split field holds transfer state
    logic [31:0] rd;
    logic [1:0] rsp;
    exec_state_pkg::core_event_type ev;
    int k;
    logic [3:0] msk; // Mask of the block under test

    // Free-running clock
    always #2.5 mclk = ~mclk;

    exec_state_unit DUT (.mclk(mclk), .rst_n(rst_n), .core_ev(core_ev), .resume(resume),
        .exec_fault(exec_fault), .irq(irq), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // Expected full view from the bench's own state
    function automatic logic [31:0] view_exp();
        logic [31:0] v;
        v = 32'h0;
        v[24] = tb_tbit;
        if (tb_xfer) begin
            v[15:12] = tb_reg;
        end else begin
            v[26:25] = tb_cond[1:0];
            v[15:10] = tb_cond[7:2];
        end
        return v;
    endfunction

    // Block advance: empty low bits end the block, else the mask shifts up
    function automatic logic [7:0] step_exp(input logic [7:0] c);
        if (c[2:0] == 3'h0) return 8'h00;
        return {c[7:5], c[3:0], 1'b0};
    endfunction

    // Block length from the mask: four minus the place of its lowest set bit
    function automatic int len_exp(input logic [3:0] m);
        for (int p = 0; p < 4; p++) begin
            if (m[p]) return 4 - p;
        end
        return 0;
    endfunction

    // One write; address and data offered together, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok) && n < 50) begin
            @(posedge mclk);
            n++;
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // Response is never in the same edge as the take
        do begin
            @(posedge mclk);
            n++;
        end while (!bvalid && n < 100);
        rsp = bresp;
        bready <= 1'b0;
        if (n >= 100) `CHK("bvalid", 1'b1, 1'b0)
    endtask

    // One read, rready held until the answer is sampled
    task automatic axi_read(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (!rvalid && n < 100);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (n >= 100) `CHK("rvalid", 1'b1, 1'b0)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_read(a);
        `CHK("rdata", e, rd)
        `CHK("rresp", er, rsp)
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        axi_write(a, d);
        `CHK("bresp", er, rsp)
    endtask

    // Drive one event for a single cycle; outputs settle after the taking edge
    task automatic pulse(input exec_state_pkg::core_event_type e);
        @(posedge mclk);
        core_ev <= e;
        @(posedge mclk);
        core_ev <= '0;
        #1;
    endtask

    task automatic end_of_test();
        $display("tests_run %0d bad_count %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog; the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        `CHK("watchdog", 1'b0, 1'b1)
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_chk(`ESV_OFS_VIEW, 32'h0100_0000, `ESV_RESP_OK);
        wr_chk(`ESV_OFS_VIEW, 32'h0, `ESV_RESP_OK);
        wr_chk(`ESV_OFS_SWVIEW, $random(seed), `ESV_RESP_OK);
        rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
        rd_chk(`ESV_OFS_SWVIEW, 32'h0, `ESV_RESP_OK);
        rd_chk(8'h10, 32'h0, `ESV_RESP_ERR);
        wr_chk(8'h14, 32'hffff_ffff, `ESV_RESP_ERR);
        rd_chk(`ESV_OFS_IRQ_MASK, 32'h0, `ESV_RESP_OK);
        $display("test reset_and_map done");
        // Suspend over a live block so stale block bits must vanish
        for (int i = 0; i < 4; i++) begin
            ev = '0;
            ev.block_start = 1'b1;
            ev.block_bits = 8'($random(seed));
            ev.block_bits[3] = 1'b1;
            pulse(ev);
            ev = '0;
            ev.xfer_suspend = 1'b1;
            ev.xfer_next = (i == 0) ? 4'hf : 4'($random(seed));
            pulse(ev);
            tb_xfer = 1'b1;
            tb_reg = ev.xfer_next;
            rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
            ev = '0;
            ev.xfer_resume = 1'b1;
            pulse(ev);
            `CHK("resume", {1'b1, tb_reg}, resume)
            ev = '0;
            ev.xfer_done = 1'b1;
            pulse(ev);
            tb_xfer = 1'b0;
            tb_cond = 8'h00;
            rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
        end
        rd_chk(`ESV_OFS_IRQ_STAT, 32'h6, `ESV_RESP_OK);
        wr_chk(`ESV_OFS_IRQ_STAT, 32'h6, `ESV_RESP_OK);
        rd_chk(`ESV_OFS_IRQ_STAT, 32'h0, `ESV_RESP_OK);
        $display("test transfer done");
        // Blocks of random conditions and lengths, stepped to the end
        for (int i = 0; i < 6; i++) begin
            ev = '0;
            ev.block_start = 1'b1;
            ev.block_bits = 8'($random(seed));
            if (ev.block_bits[3:0] == 4'h0) ev.block_bits[0] = 1'b1;
            pulse(ev);
            tb_cond = ev.block_bits;
            msk = ev.block_bits[3:0];
            rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
            k = 0;
            while (tb_cond != 8'h00 && k < 6) begin
                ev = '0;
                ev.block_step = 1'b1;
                pulse(ev);
                tb_cond = step_exp(tb_cond);
                k++;
                rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
            end
            `CHK("block_len", 1'b1, k <= 4)
            `CHK("block_steps", len_exp(msk), k)
        end
        // Corner: longest block with its steps on back-to-back edges
        ev = '0;
        ev.block_start = 1'b1;
        ev.block_bits = 8'h51;
        @(posedge mclk);
        core_ev <= ev;
        ev = '0;
        ev.block_step = 1'b1;
        repeat (4) begin
            @(posedge mclk);
            core_ev <= ev;
        end
        @(posedge mclk);
        core_ev <= '0;
        #1;
        tb_cond = 8'h00;
        rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
        $display("test block done");
        // Clear the state bit, execute, and watch the fault interrupt
        wr_chk(`ESV_OFS_IRQ_MASK, 32'h1, `ESV_RESP_OK);
        ev = '0;
        ev.tbit_load = 1'b1;
        pulse(ev);
        tb_tbit = 1'b0;
        rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
        ev = '0;
        ev.exec_try = 1'b1;
        pulse(ev);
        `CHK("exec_fault", 1'b1, exec_fault)
        repeat (2) @(posedge mclk);
        #1;
        `CHK("irq", 1'b1, irq)
        wr_chk(`ESV_OFS_IRQ_MASK, 32'h0, `ESV_RESP_OK);
        repeat (2) @(posedge mclk);
        #1;
        `CHK("irq", 1'b0, irq)
        wr_chk(`ESV_OFS_IRQ_STAT, 32'h1, `ESV_RESP_OK);
        rd_chk(`ESV_OFS_IRQ_STAT, 32'h0, `ESV_RESP_OK);
        ev = '0;
        ev.tbit_load = 1'b1;
        ev.tbit_value = 1'b1;
        pulse(ev);
        tb_tbit = 1'b1;
        ev = '0;
        ev.exec_try = 1'b1;
        pulse(ev);
        `CHK("exec_fault", 1'b0, exec_fault)
        rd_chk(`ESV_OFS_VIEW, view_exp(), `ESV_RESP_OK);
        $display("test state_bit done");
        end_of_test();
    end
endmodule // execution_state_status_bits_tb_top
